/* File: logic/isp_device.sv */
// Purpose: Device end: flash program sequencer behind the serial scan link
// Assumes: Link pins are asynchronous to sys_clk_in and sampled twice
// Notes:   Flash arrays start blank at reset in this model
//
// Contract
// R1: Serial in on tdi, data back on tdo
// R2: Host runs enter, id, erase, program, verify, exit
// R3: Verify alone skips erase and program steps
// R4: Entering programming switches pins without glitches
// R5: Host checks identity before program or verify
// R6: Erase pulse spans 500 ms idle dwell
// R7: Program pulse spans 75 us idle dwell
// R8: Verify instruction reads word for shifting out
// R9: Exiting programming restores user pins glitch free
// R10: User and configuration flash handled independently
// R11: Programming mode tri-states pins with pull-ups
// R12: Optional per-pin hold: sample, high, low, tri
// R13: Background update keeps running design alive
// R14: Reconfigure command tri-states pins while loading
// R15: Security bit blocks configuration flash readback
// R16: Only erase clears security and programmed data
// R17: User flash readable despite security bit
// R18: Pins never drive until completion bit programmed
// R19: Instruction ten bits, data word 32 bits
// R20: Flash operations ignored outside programming mode
// R21: Host aborts on any readback mismatch
`timescale 1ns/1ps
module isp_device import isp_pkg::*; #(
  parameter int          N_PINS        = 4,
  parameter int          CFG_DEPTH     = 16,
  parameter int          UFM_DEPTH     = 16,
  parameter int          UFM_SECT      = 2,
  parameter int          ERASE_CYCLES  = ERASE_CYC,
  parameter int          PROG_CYCLES   = PROG_CYC,
  parameter int          CONFIG_CYCLES = 1000,
  parameter logic [31:0] ID_CODE       = 32'h1234_5671,  // Arbitrary value
  parameter bit          INIT_DONE     = 1'b1
) (
  // Clock and reset
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_n_in,
  // Link
  isp_link_if.dev                           link,
  // Running design's pin drive
  input  wire logic [N_PINS-1:0]            user_out_in,
  input  wire logic [N_PINS-1:0]            user_oe_in,
  // Pad control
  output logic      [N_PINS-1:0]            pin_out_out,
  output logic      [N_PINS-1:0]            pin_oe_out,
  output logic      [N_PINS-1:0]            pin_pullup_out,
  // User flash port for internal logic
  input  wire logic [$clog2(UFM_DEPTH)-1:0] ufm_addr_in,
  output logic      [DR_W-1:0]              ufm_data_out,
  // Status
  output logic                              isp_mode_out,
  output logic                              cfg_load_out
);
  localparam int CI_W  = $clog2(CFG_DEPTH);
  localparam int UI_W  = $clog2(UFM_DEPTH);
  localparam int SECT_DEPTH = UFM_DEPTH / UFM_SECT;
  if ((1 << CI_W) != CFG_DEPTH || (1 << UI_W) != UFM_DEPTH || CI_W > UFM_SEL_BIT ||
      UI_W > UFM_SEL_BIT || UFM_SECT < 1 || UFM_DEPTH % UFM_SECT != 0 ||
      2 * N_PINS > DR_W || PROG_CYCLES < 1 || ERASE_CYCLES < 1 || CONFIG_CYCLES < 1)
  begin : g_bad_cfg
    $error("isp_device parameters out of range");
  end
  typedef enum logic [2:0] {P_NONE, P_ERASE_CFG, P_ERASE_UFM, P_PROG, P_SEC, P_DONE} pend_e;
  typedef struct packed {
    logic                            tck_s1, tck_s2, tck_s3;
    logic                            tms_s1, tms_s2;
    logic                            tdi_s1, tdi_s2;
    logic                            in_frame;
    logic                            is_ir;
    logic [DR_W-1:0]                 sr;
    logic [IR_W-1:0]                 ir;
    logic [ADDR_W-1:0]               addr;
    logic [DR_W-1:0]                 data;
    logic                            isp;
    logic                            bg;
    logic                            hold_en;
    logic [2*N_PINS-1:0]             hold_cfg;
    logic [N_PINS-1:0]               hold_out;
    logic [N_PINS-1:0]               hold_oe;
    pend_e                           pend;
    logic [31:0]                     tmr;
    logic                            reconf;
    logic [31:0]                     rtmr;
    logic [CFG_DEPTH-1:0][DR_W-1:0]  cfg;
    logic [UFM_DEPTH-1:0][DR_W-1:0]  user_flash_array;
    logic                            secure;
    logic                            done;
    logic [N_PINS-1:0]               pin_out, pin_oe, pin_pu;
    logic [DR_W-1:0]                 ufm_rd;
    logic                            tdo;
    logic                            cfg_load;
  } dev_s;
  localparam dev_s DEV_RST = '{cfg: '1, user_flash_array: '1, done: INIT_DONE, pin_pu: '1,
                               pend: P_NONE, default: '0};

  dev_s            q;
  dev_s            d;
  logic            rise;
  logic            ops;
  logic [IR_W-1:0] ir_v;
  logic [DR_W-1:0] rd_word;
  logic [31:0]     target;
  pin_hold_e       hmode;

  always_comb begin
    d = q;
    d.cfg_load = 1'b0;
    d.tck_s1 = link.tck;
    d.tck_s2 = q.tck_s1;
    d.tck_s3 = q.tck_s2;
    d.tms_s1 = link.tms;
    d.tms_s2 = q.tms_s1;
    d.tdi_s1 = link.tdi;
    d.tdi_s2 = q.tdi_s1;
    rise = q.tck_s2 & ~q.tck_s3;
    ops = q.isp | q.bg;
    ir_v = q.sr[DR_W-1 -: IR_W];  // see R19
    hmode = HOLD_TRI;
    target = (q.pend == P_ERASE_CFG || q.pend == P_ERASE_UFM) ?
             32'(ERASE_CYCLES) : 32'(PROG_CYCLES);
    // Configuration flash reads as zero once secured; user flash never; see R15 R17
    if (q.addr[UFM_SEL_BIT]) begin
      rd_word = q.user_flash_array[q.addr[UI_W-1:0]];
    end else begin
      rd_word = q.secure ? '0 : q.cfg[q.addr[CI_W-1:0]];
    end
    if (rise && q.tms_s2) begin
      d.pend = P_NONE;
      if (!q.in_frame) begin
        d.in_frame = 1'b1;
        d.is_ir = q.tdi_s2;
      end else begin
        d.sr = {q.tdi_s2, q.sr[DR_W-1:1]};  // see R1
      end
    end else if (rise && q.in_frame) begin
      d.in_frame = 1'b0;
      d.tmr = '0;
      if (q.is_ir) begin
        d.ir = ir_v;
        if (ir_v == IR_ENTER) begin
          d.isp = 1'b1;  // see R4
          d.hold_out = user_out_in;
          d.hold_oe = user_oe_in;
        end else if (ir_v == IR_ENTER_BG) begin
          d.bg = 1'b1;  // see R13
        end else if (ir_v == IR_EXIT) begin
          d.isp = 1'b0;  // see R9
          d.bg = 1'b0;
          d.hold_en = 1'b0;
        end else if (ir_v == IR_READ_ID) begin
          d.sr = ID_CODE;
        end else if (!ops) begin
          d.pend = P_NONE;  // see R20
        end else if (ir_v == IR_ERASE_CFG) begin
          d.pend = P_ERASE_CFG;
        end else if (ir_v == IR_ERASE_UFM) begin
          d.pend = P_ERASE_UFM;
        end else if (ir_v == IR_PROGRAM) begin
          d.pend = P_PROG;
        end else if (ir_v == IR_PROG_SEC) begin
          d.pend = P_SEC;
        end else if (ir_v == IR_PROG_DONE) begin
          d.pend = P_DONE;
        end else if (ir_v == IR_VERIFY) begin
          d.sr = rd_word;  // see R8
        end else if (ir_v == IR_RECONFIG) begin
          d.reconf = 1'b1;  // see R14
          d.rtmr = '0;
        end
      end else if (q.ir == IR_ADDR) begin
        d.addr = q.sr[ADDR_W-1:0];
      end else if (q.ir == IR_CLAMP) begin
        d.hold_cfg = q.sr[2*N_PINS-1:0];  // see R12
        d.hold_en = 1'b1;
      end else begin
        d.data = q.sr;
      end
    end else if (q.pend != P_NONE && !q.tms_s2) begin
      d.tmr = q.tmr + 32'd1;
      if (q.tmr == target - 32'd1) begin
        d.pend = P_NONE;
        case (q.pend)
          P_ERASE_CFG: begin
            d.cfg = '1;  // see R6
            d.secure = 1'b0;  // see R16
            d.done = 1'b0;
          end
          P_ERASE_UFM: begin
            for (int i = 0; i < UFM_DEPTH; i++) begin
              if (i / SECT_DEPTH == int'(q.addr[UI_W-1:0]) / SECT_DEPTH) begin
                d.user_flash_array[i] = ERASED;  // see R6 R10
              end
            end
          end
          P_PROG: begin
            if (q.addr[UFM_SEL_BIT]) begin
              d.user_flash_array[q.addr[UI_W-1:0]] = q.user_flash_array[q.addr[UI_W-1:0]] & q.data;  // see R7 R10
            end else begin
              d.cfg[q.addr[CI_W-1:0]] = q.cfg[q.addr[CI_W-1:0]] & q.data;  // see R7
            end
          end
          P_SEC: begin
            d.secure = 1'b1;
          end
          P_DONE: begin
            d.done = 1'b1;
          end
          default: begin
            d.pend = P_NONE;
          end
        endcase
      end
    end
    if (q.reconf) begin
      d.rtmr = q.rtmr + 32'd1;
      if (q.rtmr == 32'(CONFIG_CYCLES - 1)) begin
        d.reconf = 1'b0;
        d.cfg_load = 1'b1;
        d.isp = 1'b0;
        d.bg = 1'b0;
        d.hold_en = 1'b0;
      end
    end
    // Registered pad controls switch in one edge, so no glitch on mode change
    for (int p = 0; p < N_PINS; p++) begin
      hmode = pin_hold_e'(q.hold_cfg[2*p +: 2]);
      if (!q.done || q.reconf) begin
        d.pin_oe[p] = 1'b0;  // see R18 R14
        d.pin_out[p] = 1'b0;
        d.pin_pu[p] = 1'b1;
      end else if (q.isp && q.hold_en) begin
        d.pin_pu[p] = 1'b0;
        d.pin_oe[p] = (hmode == HOLD_SAMPLE) ? q.hold_oe[p] :
                      (hmode == HOLD_HIGH || hmode == HOLD_LOW);  // see R12
        d.pin_out[p] = (hmode == HOLD_SAMPLE) ? q.hold_out[p] : (hmode == HOLD_HIGH);
      end else if (q.isp) begin
        d.pin_oe[p] = 1'b0;  // see R11
        d.pin_out[p] = 1'b0;
        d.pin_pu[p] = 1'b1;
      end else begin
        d.pin_oe[p] = user_oe_in[p];  // see R13 R9
        d.pin_out[p] = user_out_in[p];
        d.pin_pu[p] = 1'b0;
      end
    end
    d.ufm_rd = q.user_flash_array[ufm_addr_in];  // see R17
    d.tdo = d.sr[0];
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign link.tdo       = q.tdo;
  assign pin_out_out    = q.pin_out;
  assign pin_oe_out     = q.pin_oe;
  assign pin_pullup_out = q.pin_pu;
  assign ufm_data_out   = q.ufm_rd;
  assign isp_mode_out   = q.isp | q.bg;
  assign cfg_load_out   = q.cfg_load;
endmodule // isp_device

/* File: logic/isp_host.sv */
// Purpose: Host end: shifts frames and times dwells on orders from AHB-Lite
// Assumes: Single word transfers, one master
// Notes:   Zero wait states; read data registered in the address phase
`timescale 1ns/1ps
module isp_host import isp_pkg::*; #(
  parameter int TCK_HALF   = 4,
  parameter int ERASE_WAIT = ERASE_CYC + WAIT_MARGIN,
  parameter int PROG_WAIT  = PROG_CYC + WAIT_MARGIN
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  // Link
  isp_link_if.host         link
);
  if (TCK_HALF < 4) begin : g_bad_half
    $error("TCK_HALF below 4 outruns the device synchroniser");
  end

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_WAIT} host_st_e;
  typedef struct packed {
    logic            ap_wr;
    logic [7:0]      ap_addr;
    logic [2:0]      op;
    logic            cmp;
    logic [31:0]     data;
    logic [31:0]     expect_w;
    logic [31:0]     rdata;
    logic            busy;
    logic            fail;
    logic            id_ok;
    logic [IR_W-1:0] last_ir;
    host_st_e        st;
    logic            is_dr;
    logic [7:0]      dcnt;
    logic [5:0]      k;
    logic [5:0]      nbits;
    logic [31:0]     shreg;
    logic [31:0]     wcnt;
    logic            tck;
    logic            tms;
    logic            tdi;
    logic            tdo_s1;
    logic            tdo_s2;
    logic [31:0]     hrdata;
  } host_s;
  localparam host_s HOST_RST = '{st: H_IDLE, default: '0};

  host_s      q;
  host_s      d;
  logic       ap_ok;
  logic       start;
  logic [9:0] code;

  always_comb begin
    d = q;
    ap_ok = hsel_in & htrans_in[1] & hready_in;
    start = 1'b0;
    code = q.data[IR_W-1:0];
    d.tdo_s1 = link.tdo;
    d.tdo_s2 = q.tdo_s1;
    d.ap_wr = ap_ok & hwrite_in;
    d.ap_addr = haddr_in[7:0];
    if (ap_ok && !hwrite_in) begin
      if (haddr_in[7:0] == A_CTRL) begin
        d.hrdata = {27'h000_0000, q.cmp, 1'b0, q.op};
      end else if (haddr_in[7:0] == A_DATA) begin
        d.hrdata = q.data;
      end else if (haddr_in[7:0] == A_EXPECT) begin
        d.hrdata = q.expect_w;
      end else if (haddr_in[7:0] == A_RDATA) begin
        d.hrdata = q.rdata;
      end else if (haddr_in[7:0] == A_STATUS) begin
        d.hrdata = {29'h0000_0000, q.id_ok, q.fail, q.busy};
      end else begin
        d.hrdata = '0;
      end
    end
    if (q.ap_wr) begin
      if (q.ap_addr == A_CTRL && !q.busy && !q.fail) begin
        d.op = hwdata_in[2:0];
        d.cmp = hwdata_in[CTRL_CMP_BIT];
        start = 1'b1;
      end else if (q.ap_addr == A_DATA && !q.busy) begin
        d.data = hwdata_in;
      end else if (q.ap_addr == A_EXPECT && !q.busy) begin
        d.expect_w = hwdata_in;
      end else if (q.ap_addr == A_STATUS && hwdata_in[ST_FAIL_BIT]) begin
        d.fail = 1'b0;
      end
    end
    if (start) begin
      d.busy = 1'b1;
      d.dcnt = '0;
      d.k = '0;
      d.tms = 1'b0;
      if (d.op == OP_IR) begin
        // Erase, program and verify need a passed identity check first; see R5
        if ((code == IR_ERASE_CFG || code == IR_ERASE_UFM || code == IR_PROGRAM ||
             code == IR_VERIFY) && !q.id_ok) begin
          d.fail = 1'b1;
          d.busy = 1'b0;
        end else begin
          d.id_ok = (code == IR_ENTER) ? 1'b0 : q.id_ok;
          d.last_ir = code;
          d.is_dr = 1'b0;
          d.nbits = 6'(IR_W);
          d.shreg = 32'(code);
          d.st = H_LOW;
        end
      end else if (d.op == OP_DR) begin
        d.is_dr = 1'b1;
        d.nbits = 6'(DR_W);
        d.shreg = q.data;
        d.st = H_LOW;
      end else if (d.op == OP_WAIT_ERASE) begin
        d.wcnt = 32'(ERASE_WAIT);  // see R6
        d.st = H_WAIT;
      end else if (d.op == OP_WAIT_PROG) begin
        d.wcnt = 32'(PROG_WAIT);  // see R7
        d.st = H_WAIT;
      end else if (d.op == OP_WAIT) begin
        d.wcnt = q.data;
        d.st = H_WAIT;
      end else begin
        d.busy = 1'b0;
      end
    end
    case (q.st)
      H_LOW: begin
        // Bit 0 is the select bit, then payload LSB first, then the update edge
        d.tms = (q.k <= q.nbits);
        d.tdi = (q.k == 6'd0) ? q.is_dr == 1'b0 : q.shreg[0];
        d.dcnt = q.dcnt + 8'd1;
        if (q.dcnt == 8'(TCK_HALF - 1)) begin
          d.dcnt = '0;
          d.tck = 1'b1;
          d.st = H_HIGH;
          if (q.k != 6'd0 && q.k <= q.nbits) begin
            d.shreg = {1'b0, q.shreg[31:1]};
            if (q.is_dr) begin
              d.rdata = {q.tdo_s2, q.rdata[31:1]};  // see R1
            end
          end
        end
      end
      H_HIGH: begin
        d.dcnt = q.dcnt + 8'd1;
        if (q.dcnt == 8'(TCK_HALF - 1)) begin
          d.dcnt = '0;
          d.tck = 1'b0;
          d.k = q.k + 6'd1;
          d.st = H_LOW;
          if (q.k == q.nbits + 6'd1) begin
            d.st = H_IDLE;
            d.busy = 1'b0;
            d.tms = 1'b0;
            if (q.is_dr && q.cmp) begin
              if (q.rdata != q.expect_w) begin
                d.fail = 1'b1;  // see R21
              end else if (q.last_ir == IR_READ_ID) begin
                d.id_ok = 1'b1;  // see R5
              end
            end
          end
        end
      end
      H_WAIT: begin
        d.tms = 1'b0;
        d.wcnt = q.wcnt - 32'd1;
        if (q.wcnt <= 32'd1) begin
          d.st = H_IDLE;
          d.busy = 1'b0;
        end
      end
      default: begin
        d.tms = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign link.tck      = q.tck;
  assign link.tms      = q.tms;
  assign link.tdi      = q.tdi;
  assign hrdata_out    = q.hrdata;
  assign hreadyout_out = rst_n_in | 1'b1;
  assign hresp_out     = 1'b0;
endmodule // isp_host

/* File: logic/isp_link_if.sv */
// Purpose: Four-wire serial scan link between host and device
// Assumes: Host makes tck; all wires are push-pull
// Notes:   tms high marks a frame, first bit selects instruction or data
`timescale 1ns/1ps
interface isp_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport host (output tck, output tms, output tdi, input tdo);
  modport dev  (input tck, input tms, input tdi, output tdo);
endinterface

/* File: logic/isp_pkg.sv */
// Purpose: Shared constants for the scan-link flash programming ends
// Assumes: 50 MHz system clock on both ends
// Notes:   Instruction codes are ten bits, data words 32 bits
package isp_pkg;
  localparam int SYS_HZ      = 50_000_000;
  localparam int ERASE_MS    = 500;
  localparam int PROG_US     = 75;
  localparam int ERASE_CYC   = (SYS_HZ / 1000) * ERASE_MS;
  localparam int PROG_CYC    = (SYS_HZ / 1_000_000) * PROG_US;
  localparam int WAIT_MARGIN = 8;
  localparam int IR_W        = 10;
  localparam int DR_W        = 32;
  localparam int ADDR_W      = 16;
  localparam int UFM_SEL_BIT = 15;
  localparam logic [DR_W-1:0] ERASED = 32'hFFFF_FFFF;
  // Instruction codes
  localparam logic [IR_W-1:0] IR_ENTER     = 10'h2CC;
  localparam logic [IR_W-1:0] IR_ENTER_BG  = 10'h2CD;
  localparam logic [IR_W-1:0] IR_EXIT      = 10'h201;
  localparam logic [IR_W-1:0] IR_READ_ID   = 10'h006;
  localparam logic [IR_W-1:0] IR_ADDR      = 10'h203;
  localparam logic [IR_W-1:0] IR_ERASE_CFG = 10'h2F2;
  localparam logic [IR_W-1:0] IR_ERASE_UFM = 10'h2F3;
  localparam logic [IR_W-1:0] IR_PROGRAM   = 10'h2F4;
  localparam logic [IR_W-1:0] IR_VERIFY    = 10'h205;
  localparam logic [IR_W-1:0] IR_CLAMP     = 10'h33F;
  localparam logic [IR_W-1:0] IR_RECONFIG  = 10'h3A0;
  localparam logic [IR_W-1:0] IR_PROG_SEC  = 10'h2F9;
  localparam logic [IR_W-1:0] IR_PROG_DONE = 10'h2FA;
  // Per-pin hold codes, two bits per pin
  typedef enum logic [1:0] {HOLD_SAMPLE, HOLD_HIGH, HOLD_LOW, HOLD_TRI} pin_hold_e;
  // Host register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_DATA   = 8'h04;
  localparam logic [7:0] A_EXPECT = 8'h08;
  localparam logic [7:0] A_RDATA  = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam int CTRL_CMP_BIT = 4;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_FAIL_BIT  = 1;
  localparam int ST_IDOK_BIT  = 2;
  // Host operations written to CTRL[2:0]
  localparam logic [2:0] OP_IR         = 3'h1;
  localparam logic [2:0] OP_DR         = 3'h2;
  localparam logic [2:0] OP_WAIT_ERASE = 3'h3;
  localparam logic [2:0] OP_WAIT_PROG  = 3'h4;
  localparam logic [2:0] OP_WAIT       = 3'h5;
endpackage

/* File: logic/unused_placeholder_none.sv */
`timescale 1ns/1ps

/* File: testbench/isp_checker.sv */
// Purpose: Link wire checks between host and device ends
// Assumes: Host built with TCK_HALF of 4
// Notes:   Sees only the four link wires plus clock and reset
`timescale 1ns/1ps
module isp_checker (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Link wires
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  logic       tck_q;
  logic [5:0] rise_cnt_q;

  // Counts tck rises inside one frame
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tck_q      <= 1'b0;
      rise_cnt_q <= 6'h0;
    end else begin
      tck_q <= tck;
      if (tms && tck && !tck_q) begin
        rise_cnt_q <= rise_cnt_q + 6'h1;
      end else if (!tms) begin
        rise_cnt_q <= 6'h0;
      end
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  tck_high_a: assert property ($rose(tck) |-> tck[*4] ##1 !tck)
    else $error("tck high phase wrong");
  tck_low_a: assert property ($fell(tck) |-> !tck[*4])
    else $error("tck low phase short");
  tms_edge_a: assert property ($changed(tms) |-> !tck)
    else $error("tms moved while tck high");
  tdi_edge_a: assert property ($changed(tdi) |-> !tck)
    else $error("tdi moved while tck high");
  frame_len_a: assert property ($fell(tms) |-> rise_cnt_q inside {6'd11, 6'd33})
    else $error("frame bit count wrong");
  update_tck_a: assert property ($fell(tms) |-> ##[1:5] $rose(tck))
    else $error("no update clock after frame");
  select_tck_a: assert property ($rose(tms) |-> !tck ##[1:5] $rose(tck))
    else $error("no select clock after frame start");
  tdo_hold_a: assert property ($changed(tdo) |=> $stable(tdo)[*3])
    else $error("tdo not held between shifts");
endmodule // isp_checker

/* File: testbench/tb_top.sv */
// Purpose: Host and device ends joined, driven over AHB-Lite
// Assumes: Shortened dwell counts on both ends
// Notes:   Results judged from host registers and device pads
`timescale 1ns/1ps
`define check_eq(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top import isp_pkg::*;;
  localparam logic [31:0] ID_CODE = 32'h0A5C_3E01;  // Arbitrary value
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        hsel_in = 1'b0;
  logic        hwrite_in = 1'b0;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h0;
  logic [31:0] haddr_in = 32'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic        hreadyout_out;
  logic        hresp_out;
  logic [31:0] hrdata_out;
  logic [3:0]  user_out_in = 4'h5;
  logic [3:0]  user_oe_in = 4'hF;
  logic [3:0]  ufm_addr_in = 4'h0;
  logic [3:0]  pin_out_out;
  logic [3:0]  pin_oe_out;
  logic [3:0]  pin_pullup_out;
  logic [31:0] ufm_data_out;
  logic        isp_mode_out;
  logic        cfg_load_out;
  logic [31:0] rd;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  isp_link_if isp_link_if_i ();
  isp_host #(.ERASE_WAIT(208), .PROG_WAIT(28)) isp_host_i (.sys_clk_in, .rst_n_in,
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
    .hready_in(hreadyout_out), .hreadyout_out, .hrdata_out, .hresp_out,
    .link(isp_link_if_i));
  isp_device #(.ERASE_CYCLES(200), .PROG_CYCLES(20),
    .ID_CODE(ID_CODE)) isp_device_i (.sys_clk_in, .rst_n_in, .link(isp_link_if_i),
    .user_out_in, .user_oe_in, .pin_out_out, .pin_oe_out, .pin_pullup_out,
    .ufm_addr_in, .ufm_data_out, .isp_mode_out, .cfg_load_out);
  isp_checker isp_checker_i (.sys_clk_in, .rst_n_in, .tck(isp_link_if_i.tck),
    .tms(isp_link_if_i.tms), .tdi(isp_link_if_i.tdi), .tdo(isp_link_if_i.tdo));

  always #10 sys_clk_in = ~sys_clk_in;

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hsize_in <= 3'h2;
    hwrite_in <= w;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask

  // Starts one host operation and polls until it is over
  task automatic op(input logic [7:0] ctrl, input logic [31:0] d);
    bus(1'b1, A_DATA, d);
    bus(1'b1, A_CTRL, {24'h0, ctrl});
    do bus(1'b0, A_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic ir(input logic [9:0] c);
    op({5'h0, OP_IR}, {22'h0, c});
  endtask

  task automatic dr(input logic [31:0] d, input logic cmp, input logic [31:0] e);
    bus(1'b1, A_EXPECT, e);
    op({3'h0, cmp, 1'b0, OP_DR}, d);
  endtask

  task automatic enter(input logic [9:0] c);
    ir(c);
    ir(IR_READ_ID);
    dr(32'h0, 1'b1, ID_CODE);
    bus(1'b0, A_STATUS, 32'h0);
    `check_eq(rd[2:1], 2'b10)
  endtask

  task automatic rd_word(input logic [15:0] a);
    ir(IR_ADDR);
    dr({16'h0, a}, 1'b0, 32'h0);
    ir(IR_VERIFY);
    dr(32'h0, 1'b0, 32'h0);
    bus(1'b0, A_RDATA, 32'h0);
  endtask

  task automatic wr_word(input logic [15:0] a, input logic [31:0] d);
    ir(IR_ADDR);
    dr({16'h0, a}, 1'b0, 32'h0);
    // A data frame must follow an instruction that starts no dwell
    ir(IR_VERIFY);
    dr(d, 1'b0, 32'h0);
    ir(IR_PROGRAM);
    op({5'h0, OP_WAIT_PROG}, 32'h0);
  endtask

  task automatic t_refuse();
    ir(IR_ERASE_CFG);
    `check_eq(rd[ST_FAIL_BIT], 1'b1)
    bus(1'b1, A_STATUS, 32'h2);
    ir(IR_READ_ID);
    dr(32'h0, 1'b1, ID_CODE);
    wr_word(16'h8001, 32'h0);
    `check_eq(isp_mode_out, 1'b0)
  endtask

  task automatic t_prog();
    enter(IR_ENTER);
    `check_eq({isp_mode_out, pin_oe_out, pin_pullup_out}, 9'h10F)
    rd_word(16'h8001);
    `check_eq(rd, ERASED)
    wr_word(16'h8003, 32'hA5A5_0F0F);
    wr_word(16'h0002, 32'h1234_ABCD);
    rd_word(16'h8003);
    `check_eq(rd, 32'hA5A5_0F0F)
    rd_word(16'h0002);
    `check_eq(rd, 32'h1234_ABCD)
    ufm_addr_in <= 4'h3;
    repeat (2) @(posedge sys_clk_in);
    `check_eq(ufm_data_out, 32'hA5A5_0F0F)
  endtask

  task automatic t_secure();
    ir(IR_PROG_SEC);
    op({5'h0, OP_WAIT_PROG}, 32'h0);
    rd_word(16'h0002);
    `check_eq(rd, 32'h0)
    rd_word(16'h8003);
    `check_eq(rd, 32'hA5A5_0F0F)
    ir(IR_ERASE_CFG);
    op({5'h0, OP_WAIT_ERASE}, 32'h0);
    rd_word(16'h0002);
    `check_eq(rd, ERASED)
    rd_word(16'h8003);
    `check_eq(rd, 32'hA5A5_0F0F)
    ir(IR_ADDR);
    dr(32'h8000, 1'b0, 32'h0);
    ir(IR_ERASE_UFM);
    op({5'h0, OP_WAIT_ERASE}, 32'h0);
    rd_word(16'h8003);
    `check_eq(rd, ERASED)
  endtask

  task automatic t_pins();
    ir(IR_EXIT);
    `check_eq({isp_mode_out, pin_oe_out, pin_pullup_out}, 9'h00F)
    enter(IR_ENTER);
    // Running design changes its drive after the hold values were sampled
    user_out_in <= 4'hA;
    user_oe_in <= 4'h3;
    ir(IR_PROG_DONE);
    op({5'h0, OP_WAIT_PROG}, 32'h0);
    ir(IR_CLAMP);
    dr(32'hE4, 1'b0, 32'h0);
    `check_eq({pin_oe_out, pin_out_out}, 8'h73)
    ir(IR_EXIT);
    `check_eq({isp_mode_out, pin_oe_out, pin_out_out, pin_pullup_out}, 13'h03A0)
    enter(IR_ENTER_BG);
    `check_eq({isp_mode_out, pin_oe_out}, 5'h13)
    ir(IR_RECONFIG);
    `check_eq({pin_oe_out, pin_pullup_out}, 8'h0F)
    for (int i = 0; i < 1100 && cfg_load_out !== 1'b1; i++) @(posedge sys_clk_in);
    `check_eq({cfg_load_out, isp_mode_out}, 2'b10)
  endtask

  task automatic t_verify();
    enter(IR_ENTER);
    rd_word(16'h0002);
    `check_eq(rd, ERASED)
    ir(IR_EXIT);
    `check_eq(isp_mode_out, 1'b0)
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    t_refuse();
    t_prog();
    t_secure();
    t_pins();
    t_verify();
    end_of_test();
  end
endmodule // tb_top
